// *** bench/core_ctrl_props.sv ***
// checker for the pointer, power and timer control bank
// assumes binding to the design top, ports watched by name
module core_ctrl_props (
  // clock and reset
  input wire clock_i,
  input wire sys_rst_i,
  // register port and events
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire write_i,
  input wire wakeup_i,
  input wire timer1_overflow_i,
  input wire timer1_vector_i,
  input wire ext_irq0_pin_i,
  input wire ext_irq1_pin_i,
  // outputs
  input wire [15:0] data_pointer_word_o,
  input wire baud_doubler_o,
  input wire timer1_run_o,
  input wire timer0_run_o,
  input wire timer1_overflow_flag_o,
  input wire ext_irq0_flag_o,
  input wire ext_irq1_flag_o,
  input wire ext_irq0_trigger_type_o,
  input wire ext_irq1_trigger_type_o,
  input wire cpu_clock_enable_o,
  input wire periph_clock_enable_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  wire w87 = write_i && addr_i == 8'h87;
  wire w88 = write_i && addr_i == 8'h88;
  ptr_low_a: assert property (write_i && addr_i == 8'h82 |=> data_pointer_word_o[7:0] == $past(wdata_i))
    else $error("pointer low byte not loaded");
  ptr_high_a: assert property (write_i && addr_i == 8'h83 |=> data_pointer_word_o[15:8] == $past(wdata_i))
    else $error("pointer high byte not loaded");
  baud_bit_a: assert property (w87 |=> baud_doubler_o == $past(wdata_i[7]))
    else $error("baud doubler not loaded");
  power_down_a: assert property (w87 && wdata_i[1] && !wakeup_i |=> !periph_clock_enable_o && !cpu_clock_enable_o)
    else $error("power down left a clock running");
  light_sleep_a: assert property (w87 && wdata_i[1:0] == 2'b01 && !wakeup_i && periph_clock_enable_o
    |=> !cpu_clock_enable_o && periph_clock_enable_o) else $error("light sleep clocks wrong");
  overflow_set_a: assert property (timer1_overflow_i |=> timer1_overflow_flag_o)
    else $error("overflow flag not set");
  vector_clear_a: assert property (timer1_vector_i && !timer1_overflow_i && !w88 |=> !timer1_overflow_flag_o)
    else $error("overflow flag not cleared on vector");
  run_bits_a: assert property (w88 |=> {timer1_run_o, timer0_run_o} == {$past(wdata_i[6]), $past(wdata_i[4])})
    else $error("run bits not loaded");
  level_track_a: assert property (!ext_irq0_trigger_type_o && !write_i |=> ext_irq0_flag_o == !$past(ext_irq0_pin_i))
    else $error("level flag not following pin");
  edge_set_a: assert property (ext_irq1_trigger_type_o && $fell(ext_irq1_pin_i) |-> ##[1:2] ext_irq1_flag_o)
    else $error("edge flag not set");
  cover property (timer1_vector_i && timer1_overflow_flag_o);
  cover property (ext_irq1_flag_o && ext_irq1_trigger_type_o);
  cover property (!cpu_clock_enable_o && periph_clock_enable_o);
endmodule
bind core_pointer_power_timer_ctrl core_ctrl_props chk (.*);

// *** bench/core_pointer_power_timer_ctrl_tb_top.sv ***
// self-checking bench for the pointer, power and timer control bank
// assumes rdata_o one cycle after read_i and pins synchronous to clock_i
module core_pointer_power_timer_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i = 0, sys_rst_i = 1, write_i = 0, read_i = 0, fe = 0;
  logic [7:0] addr_i = 0, wdata_i = 0;
  logic [8:0] ev = 0;
  logic [1:0] p = 2'b11;
  wire [7:0] rdata_o;
  wire [15:0] dp;
  wire [11:0] o;
  bit [7:0] mdl [256];
  bit sm0;
  int n_mismatch = 0, samples_checked = 0;
  core_pointer_power_timer_ctrl dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .brownout_event_i(ev[7]), .power_on_event_i(ev[8]),
    .frame_error_i(fe), .timer1_overflow_i(ev[0]), .timer0_overflow_i(ev[1]), .timer1_vector_i(ev[2]),
    .timer0_vector_i(ev[3]), .ext_irq1_vector_i(ev[4]), .ext_irq0_vector_i(ev[5]), .ext_irq1_pin_i(p[1]),
    .ext_irq0_pin_i(p[0]), .data_pointer_word_o(dp), .baud_doubler_o(o[8]), .serial_mode0_o(o[9]),
    .timer1_run_o(o[6]), .timer0_run_o(o[4]), .timer1_overflow_flag_o(o[7]), .timer0_overflow_flag_o(o[5]),
    .ext_irq1_flag_o(o[3]), .ext_irq0_flag_o(o[1]), .ext_irq1_trigger_type_o(o[2]),
    .ext_irq0_trigger_type_o(o[0]), .cpu_clock_enable_o(o[10]), .periph_clock_enable_o(o[11]), .wakeup_i(ev[6]));
  initial forever #2.5 clock_i = ~clock_i;
  task chk(input logic [27:0] g, e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // model: sleep bits only clear on wakeup, ext flags never written here
  task wr(input logic [7:0] a, d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    write_i <= 1;
    @(posedge clock_i);
    write_i <= 0;
    @(negedge clock_i);
    case (a)
      8'h82, 8'h83: mdl[a] = d;
      8'h87: mdl[a] = d | (mdl[a] & 8'h03);
      8'h88: mdl[a] = (d & 8'hF5) | (mdl[a] & 8'h0A);
      8'h98: if (!mdl[135][6]) sm0 = d[7];
      default: ;
    endcase
  endtask
  task rd(input logic [7:0] a);
    @(posedge clock_i);
    addr_i <= a;
    read_i <= 1;
    @(posedge clock_i);
    read_i <= 0;
    @(negedge clock_i);
    chk(rdata_o, a == 8'h98 ? {mdl[135][6] ? fe : sm0, 7'h00} : mdl[a]);
    chk({dp, o}, {mdl[131], mdl[130], ~mdl[135][1], ~|mdl[135][1:0], sm0, mdl[135][7], mdl[136]});
  endtask
  task pulse(input int b);
    @(posedge clock_i);
    ev[b] <= 1;
    @(posedge clock_i);
    ev[b] <= 0;
    @(negedge clock_i);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    finish_test;
  end
  initial begin
    void'($urandom(93));
    repeat (20) @(posedge clock_i);
    sys_rst_i <= 0;
    for (logic [7:0] a = 8'h80; a < 8'h8A; a++) rd(a);
    repeat (4) begin
      wr(8'h82, 8'($urandom));
      wr(8'h83, 8'($urandom));
      wr(8'h87, 8'($urandom) & 8'hCC);
      rd(8'h87);
    end
    wr(8'h55, 8'hFF);
    rd(8'h55);
    $display("done pointer and power");
    wr(8'h87, 8'h00);
    wr(8'h98, 8'hFF);
    rd(8'h98);
    wr(8'h87, 8'h40);
    @(posedge clock_i) fe <= 1;
    rd(8'h98);
    wr(8'h98, 8'h00);
    @(posedge clock_i) fe <= 0;
    rd(8'h98);
    wr(8'h87, 8'h41);
    wr(8'h87, 8'h40);
    rd(8'h87);
    pulse(6);
    mdl[135] &= 8'hFC;
    wr(8'h87, 8'h42);
    rd(8'h87);
    pulse(6);
    mdl[135] &= 8'hFC;
    rd(8'h87);
    $display("done sleep");
    wr(8'h88, 8'h50);
    pulse(0);
    pulse(1);
    mdl[136] |= 8'hA0;
    rd(8'h88);
    pulse(2);
    mdl[136] &= 8'h7F;
    rd(8'h88);
    pulse(3);
    mdl[136] &= 8'hDF;
    rd(8'h88);
    wr(8'h88, 8'hA0);
    rd(8'h88);
    wr(8'h88, 8'h00);
    rd(8'h88);
    $display("done timer flags");
    @(posedge clock_i) p <= 2'b10;
    repeat (2) @(posedge clock_i);
    mdl[136] = 8'h02;
    pulse(5);
    rd(8'h88);
    @(posedge clock_i) p <= 2'b11;
    repeat (2) @(posedge clock_i);
    mdl[136] = 8'h00;
    rd(8'h88);
    wr(8'h88, 8'h05);
    @(posedge clock_i) p <= 2'b00;
    repeat (2) @(posedge clock_i);
    mdl[136] = 8'h0F;
    rd(8'h88);
    @(posedge clock_i) p <= 2'b11;
    repeat (2) @(posedge clock_i);
    rd(8'h88);
    pulse(4);
    pulse(5);
    mdl[136] = 8'h05;
    rd(8'h88);
    pulse(7);
    pulse(8);
    mdl[135] |= 8'h30;
    rd(8'h87);
    $display("done external and cause flags");
    finish_test;
  end
endmodule

// *** core/core_pointer_power_timer_ctrl.v ***
// pointer, power control and timer/interrupt control register bank
// assumes a single-cycle strobe register port, inputs synchronous to clock_i
// Function
// - the low byte of the data pointer is a readable and writable register.
// - the high byte of the data pointer is a second register and joins the low byte into the word.
// - with frame check select clear, serial control bit 7 reads and writes as mode bit 0.
// - with frame check select set, serial control bit 7 reads as the framing error flag.
// - writing one to the power down request stops all clocks and freezes execution.
// - timer overflows set their overflow flags at bits 7 and 5.
// - a timer overflow flag is cleared when its service routine is vectored to.
// - software can both set and clear either timer overflow flag.
// - the timer run bits 6 and 4 are software controlled and start or halt the timers.
// - a selected edge or level on an external interrupt pin sets its flag at bit 3 or 1.
// - vectoring clears an external interrupt flag only in edge triggered mode.
// - in level mode an external interrupt flag follows the inverse of its pin.
// - trigger type bits 2 and 0 select falling edge when one and low level when zero.
//
// Local design decision: the plain strobed port.
`include "core_ptr_consts.vh"
module core_pointer_power_timer_ctrl #(
  parameter ADDR_WIDTH = 8,
  parameter DATA_WIDTH = 8
) (
  // clock and reset
  input wire clock_i,
  input wire sys_rst_i,
  // register port
  input wire [ADDR_WIDTH-1:0] addr_i,
  input wire [DATA_WIDTH-1:0] wdata_i,
  input wire write_i,
  input wire read_i,
  output reg [DATA_WIDTH-1:0] rdata_o,
  // reset cause and serial status
  input wire brownout_event_i,
  input wire power_on_event_i,
  input wire frame_error_i,
  // timer and interrupt events
  input wire timer1_overflow_i,
  input wire timer0_overflow_i,
  input wire timer1_vector_i,
  input wire timer0_vector_i,
  input wire ext_irq1_vector_i,
  input wire ext_irq0_vector_i,
  input wire ext_irq1_pin_i,
  input wire ext_irq0_pin_i,
  // control outputs
  output wire [15:0] data_pointer_word_o,
  output wire baud_doubler_o,
  output wire serial_mode0_o,
  output wire timer1_run_o,
  output wire timer0_run_o,
  output wire timer1_overflow_flag_o,
  output wire timer0_overflow_flag_o,
  output wire ext_irq1_flag_o,
  output wire ext_irq0_flag_o,
  output wire ext_irq1_trigger_type_o,
  output wire ext_irq0_trigger_type_o,
  output wire cpu_clock_enable_o,
  output wire periph_clock_enable_o,
  // wakeup
  input wire wakeup_i
);
  reg [7:0] pointer_low_byte;
  reg [7:0] pointer_high_byte;
  reg baud_doubler;
  reg frame_check_select;
  reg brownout_flag;
  reg power_on_flag;
  reg user_flag_1;
  reg user_flag_0;
  reg power_down_request;
  reg light_sleep_request;
  reg timer1_overflow_flag;
  reg timer0_overflow_flag;
  reg timer1_run;
  reg timer0_run;
  reg ext_irq1_trigger_type;
  reg ext_irq0_trigger_type;
  reg serial_mode0;
  reg [DATA_WIDTH-1:0] next_rdata;
  wire ext_irq1_flag;
  wire ext_irq0_flag;

  function hit;
    input [ADDR_WIDTH-1:0] a;
    input [7:0] target;
    begin
      hit = (a == target[ADDR_WIDTH-1:0]);
    end
  endfunction

  wire wr_pl = write_i & hit(addr_i, `ADDR_POINTER_LOW);
  wire wr_ph = write_i & hit(addr_i, `ADDR_POINTER_HIGH);
  wire wr_pc = write_i & hit(addr_i, `ADDR_POWER_CONTROL);
  wire wr_tc = write_i & hit(addr_i, `ADDR_TIMER_IRQ_CONTROL);
  wire wr_sc = write_i & hit(addr_i, `ADDR_SERIAL_CONTROL);

  // read data is a flop, so it stands only in the cycle after the strobe
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= `RESET_BYTE;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pointer_low_byte <= `RESET_BYTE;
    end else if (wr_pl) begin
      pointer_low_byte <= wdata_i[7:0];
    end
  end

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pointer_high_byte <= `RESET_BYTE;
    end else if (wr_ph) begin
      pointer_high_byte <= wdata_i[7:0];
    end
  end

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      baud_doubler <= 1'b0;
    end else if (wr_pc) begin
      baud_doubler <= wdata_i[`PC_BAUD_DOUBLER];
    end
  end

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      frame_check_select <= 1'b0;
    end else if (wr_pc) begin
      frame_check_select <= wdata_i[`PC_FRAME_CHECK_SELECT];
    end
  end

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      user_flag_1 <= 1'b0;
    end else if (wr_pc) begin
      user_flag_1 <= wdata_i[`PC_USER_FLAG_1];
    end
  end

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      user_flag_0 <= 1'b0;
    end else if (wr_pc) begin
      user_flag_0 <= wdata_i[`PC_USER_FLAG_0];
    end
  end

  // cause flags: hardware set wins over software write
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      brownout_flag <= 1'b0;
    end else if (brownout_event_i) begin
      brownout_flag <= 1'b1;
    end else if (wr_pc) begin
      brownout_flag <= wdata_i[`PC_BROWNOUT_FLAG];
    end
  end

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      power_on_flag <= 1'b0;
    end else if (power_on_event_i) begin
      power_on_flag <= 1'b1;
    end else if (wr_pc) begin
      power_on_flag <= wdata_i[`PC_POWER_ON_FLAG];
    end
  end

  // sleep requests self-clear on wakeup so execution resumes
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      power_down_request <= 1'b0;
    end else if (wr_pc && wdata_i[`PC_POWER_DOWN_REQUEST]) begin
      power_down_request <= 1'b1;
    end else if (wakeup_i) begin
      power_down_request <= 1'b0;
    end
  end

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      light_sleep_request <= 1'b0;
    end else if (wr_pc && wdata_i[`PC_LIGHT_SLEEP_REQUEST]) begin
      light_sleep_request <= 1'b1;
    end else if (wakeup_i) begin
      light_sleep_request <= 1'b0;
    end
  end

  // mode bit is only written when the frame flag is not shown
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      serial_mode0 <= 1'b0;
    end else if (wr_sc && !frame_check_select) begin
      serial_mode0 <= wdata_i[7];
    end
  end

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timer1_run <= 1'b0;
    end else if (wr_tc) begin
      timer1_run <= wdata_i[`TC_TIMER1_RUN];
    end
  end

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timer0_run <= 1'b0;
    end else if (wr_tc) begin
      timer0_run <= wdata_i[`TC_TIMER0_RUN];
    end
  end

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ext_irq1_trigger_type <= 1'b0;
    end else if (wr_tc) begin
      ext_irq1_trigger_type <= wdata_i[`TC_EXT_IRQ1_TRIGGER_TYPE];
    end
  end

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ext_irq0_trigger_type <= 1'b0;
    end else if (wr_tc) begin
      ext_irq0_trigger_type <= wdata_i[`TC_EXT_IRQ0_TRIGGER_TYPE];
    end
  end

  // set wins, so an overflow in the cycle of a clear is never lost
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timer1_overflow_flag <= 1'b0;
    end else if (timer1_overflow_i) begin
      timer1_overflow_flag <= 1'b1;
    end else if (wr_tc) begin
      timer1_overflow_flag <= wdata_i[`TC_TIMER1_OVERFLOW_FLAG];
    end else if (timer1_vector_i) begin
      timer1_overflow_flag <= 1'b0;
    end
  end

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timer0_overflow_flag <= 1'b0;
    end else if (timer0_overflow_i) begin
      timer0_overflow_flag <= 1'b1;
    end else if (wr_tc) begin
      timer0_overflow_flag <= wdata_i[`TC_TIMER0_OVERFLOW_FLAG];
    end else if (timer0_vector_i) begin
      timer0_overflow_flag <= 1'b0;
    end
  end

  ext_irq_flag irq1_flag (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(ext_irq1_pin_i),
    .trigger_type_i(ext_irq1_trigger_type),
    .vector_ack_i(ext_irq1_vector_i),
    .sw_write_i(wr_tc),
    .sw_value_i(wdata_i[`TC_EXT_IRQ1_FLAG]),
    .flag_o(ext_irq1_flag)
  );

  ext_irq_flag irq0_flag (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(ext_irq0_pin_i),
    .trigger_type_i(ext_irq0_trigger_type),
    .vector_ack_i(ext_irq0_vector_i),
    .sw_write_i(wr_tc),
    .sw_value_i(wdata_i[`TC_EXT_IRQ0_FLAG]),
    .flag_o(ext_irq0_flag)
  );

  always @* begin
    next_rdata = {DATA_WIDTH{1'b0}};
    if (read_i) begin
      if (hit(addr_i, `ADDR_POINTER_LOW)) begin
        next_rdata[7:0] = pointer_low_byte;
      end else if (hit(addr_i, `ADDR_POINTER_HIGH)) begin
        next_rdata[7:0] = pointer_high_byte;
      end else if (hit(addr_i, `ADDR_POWER_CONTROL)) begin
        next_rdata[7:0] = {baud_doubler, frame_check_select, brownout_flag, power_on_flag,
                           user_flag_1, user_flag_0, power_down_request, light_sleep_request};
      end else if (hit(addr_i, `ADDR_TIMER_IRQ_CONTROL)) begin
        next_rdata[7:0] = {timer1_overflow_flag, timer1_run, timer0_overflow_flag, timer0_run,
                           ext_irq1_flag, ext_irq1_trigger_type, ext_irq0_flag, ext_irq0_trigger_type};
      end else if (hit(addr_i, `ADDR_SERIAL_CONTROL)) begin
        next_rdata[7] = frame_check_select ? frame_error_i : serial_mode0;
      end
    end
  end

  assign data_pointer_word_o = {pointer_high_byte, pointer_low_byte};
  assign baud_doubler_o = baud_doubler;
  assign serial_mode0_o = serial_mode0;
  assign timer1_run_o = timer1_run;
  assign timer0_run_o = timer0_run;
  assign timer1_overflow_flag_o = timer1_overflow_flag;
  assign timer0_overflow_flag_o = timer0_overflow_flag;
  assign ext_irq1_flag_o = ext_irq1_flag;
  assign ext_irq0_flag_o = ext_irq0_flag;
  assign ext_irq1_trigger_type_o = ext_irq1_trigger_type;
  assign ext_irq0_trigger_type_o = ext_irq0_trigger_type;
  // peripherals keep their clock in light sleep, not in power down
  assign cpu_clock_enable_o = ~(power_down_request | light_sleep_request);
  assign periph_clock_enable_o = ~power_down_request;
endmodule

// *** core/core_ptr_consts.vh ***
// register offsets, field positions and reset values of the pointer, power and timer control bank
// assumes inclusion by core/*.v only
`ifndef CORE_PTR_CONSTS_VH
`define CORE_PTR_CONSTS_VH
`define ADDR_POINTER_LOW 8'h82
`define ADDR_POINTER_HIGH 8'h83
`define ADDR_POWER_CONTROL 8'h87
`define ADDR_TIMER_IRQ_CONTROL 8'h88
`define ADDR_SERIAL_CONTROL 8'h98
`define PC_BAUD_DOUBLER 7
`define PC_FRAME_CHECK_SELECT 6
`define PC_BROWNOUT_FLAG 5
`define PC_POWER_ON_FLAG 4
`define PC_USER_FLAG_1 3
`define PC_USER_FLAG_0 2
`define PC_POWER_DOWN_REQUEST 1
`define PC_LIGHT_SLEEP_REQUEST 0
`define TC_TIMER1_OVERFLOW_FLAG 7
`define TC_TIMER1_RUN 6
`define TC_TIMER0_OVERFLOW_FLAG 5
`define TC_TIMER0_RUN 4
`define TC_EXT_IRQ1_FLAG 3
`define TC_EXT_IRQ1_TRIGGER_TYPE 2
`define TC_EXT_IRQ0_FLAG 1
`define TC_EXT_IRQ0_TRIGGER_TYPE 0
`define RESET_BYTE 8'h00
`endif

// *** core/ext_irq_flag.v ***
// one external interrupt flag with edge or level capture
// assumes pin synchronous to clock_i, pin is active low
module ext_irq_flag (
  // clock and reset
  input wire clock_i,
  input wire sys_rst_i,
  // pin and control
  input wire pin_i,
  input wire trigger_type_i,
  input wire vector_ack_i,
  input wire sw_write_i,
  input wire sw_value_i,
  // flag
  output reg flag_o
);
  reg pin_prev;
  wire falling;
  assign falling = pin_prev & ~pin_i;
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_prev <= 1'b1;
      flag_o <= 1'b0;
    end else begin
      pin_prev <= pin_i;
      if (!trigger_type_i)
        flag_o <= ~pin_i;
      else if (falling)
        flag_o <= 1'b1; // set wins over clear
      else if (sw_write_i)
        flag_o <= sw_value_i;
      else if (vector_ack_i)
        flag_o <= 1'b0;
    end
  end
endmodule
